/* pmc_cfg.svh */
// Register offsets, field positions, reset values and masks for the mode control block
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
`define PMC_OFF_FEAT_LO 12'h000
`define PMC_OFF_FEAT_HI 12'h004
`define PMC_OFF_CTL0 12'h008
`define PMC_OFF_FLAGS 12'h00c
`define PMC_OFF_CS 12'h010
`define PMC_OFF_CTRL 12'h014
`define PMC_OFF_MODE 12'h018
`define PMC_OFF_PRIO 12'h01c
`define PMC_OFF_GDT_LO 12'h020
`define PMC_OFF_GDT_HI 12'h024
`define PMC_OFF_IDT_LO 12'h028
`define PMC_OFF_IDT_HI 12'h02c
`define PMC_OFF_LDT_LO 12'h030
`define PMC_OFF_LDT_HI 12'h034
`define PMC_OFF_TSR_LO 12'h038
`define PMC_OFF_TSR_HI 12'h03c
`define PMC_OFF_BKP_LO 12'h040
`define PMC_OFF_BKP_HI 12'h044
`define PMC_BIT_FAST_CALL 0
`define PMC_BIT_LONG_EN 8
`define PMC_BIT_LONG_ACT 10
`define PMC_BIT_XD_EN 11
`define PMC_BIT_PROT_EN 0
`define PMC_BIT_PG 31
`define PMC_BIT_V86 17
`define PMC_BIT_CSL 0
`define PMC_BIT_RESUME 0
`define PMC_FEAT_WMASK 32'h00000901
`define PMC_RESET_WORD 32'h00000000
`define PMC_PRIO_MASK 32'h0000000f
`endif

/* pmc_pkg.sv */
// Types shared by the mode control block
package pmc_pkg;
	typedef enum logic [2:0] {
		PMC_REAL = 3'h0,
		PMC_PROT = 3'h1,
		PMC_V86 = 3'h2,
		PMC_COMPAT = 3'h3,
		PMC_BIT64 = 3'h4,
		PMC_MGMT = 3'h5
	} pmc_mode_type;
	typedef enum {PMC_RUN, PMC_IN_MGMT} pmc_state_type;
endpackage

/* pmc_wide_reg.sv */
// One wide system register whose upper half only exists in long mode
`timescale 1ns/1ps
module pmc_wide_reg #(
	parameter int WIDTH = 64
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wide_en,
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [31:0] wdata,
	output logic [WIDTH-1:0] value
);
	logic [WIDTH-1:0] next_value; // Next contents

	// Low word always writable, high word only while wide
	always_comb begin
		next_value = value;
		if (wr_lo) begin
			next_value[31:0] = wdata;
		end
		if (wr_hi && wide_en) begin
			next_value[WIDTH-1:32] = wdata[WIDTH-33:0];
		end
		// Leaving long mode truncates, so stale upper bits never leak back
		if (!wide_en) begin
			next_value[WIDTH-1:32] = '0;
		end
	end

	// Storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value <= '0;
		end else begin
			value <= next_value;
		end
	end
endmodule // pmc_wide_reg

/* pmc_mgmt_entry.sv */
// Turns each activation of the management interrupt pin into a one-cycle request
`timescale 1ns/1ps
module pmc_mgmt_entry (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic mgmt_interrupt_pin_n,
	output logic mgmt_req
);
	logic pin_prev_n; // Last pin level, idle high
	logic next_pin_prev_n; // Next pin level

	// Falling edge is one activation
	always_comb begin
		next_pin_prev_n = mgmt_interrupt_pin_n;
		mgmt_req = pin_prev_n && !mgmt_interrupt_pin_n;
	end

	// Edge history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_prev_n <= 1'b1;
		end else begin
			pin_prev_n <= next_pin_prev_n;
		end
	end
endmodule // pmc_mgmt_entry

/* pmc_mode_ctrl.sv */
// Operating-mode control: mode tracking, management mode, feature register, APB slave
`include "pmc_cfg.svh"
`timescale 1ns/1ps
module pmc_mode_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mgmt_interrupt_pin_n,
	output pmc_pkg::pmc_mode_type current_mode,
	output logic fast_call_allowed,
	output logic execute_disable_enable,
	output logic mgmt_address_space
);
	import pmc_pkg::*;

	logic [31:0] feat_lo; // Feature register low word, writable bits only
	logic [31:0] control_reg_zero; // Low word of control register zero
	logic [31:0] system_flags_register; // Low word of flags
	logic [31:0] cs_attr; // Current code segment attributes
	logic [31:0] priority_control_reg; // Task priority level
	logic long_mode_active; // Hardware-owned active bit
	pmc_state_type state; // Running or in management mode
	pmc_mode_type saved_mode; // Mode to return to
	logic [31:0] saved_ctl0; // Saved context
	logic [31:0] saved_flags; // Saved context
	logic [31:0] saved_cs; // Saved context
	logic [31:0] next_feat_lo;
	logic [31:0] next_control_reg_zero;
	logic [31:0] next_system_flags_register;
	logic [31:0] next_cs_attr;
	logic [31:0] next_priority_control_reg;
	logic next_long_mode_active;
	pmc_state_type next_state;
	pmc_mode_type next_saved_mode;
	logic [31:0] next_saved_ctl0;
	logic [31:0] next_saved_flags;
	logic [31:0] next_saved_cs;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic wr; // Write takes effect this edge
	logic rd; // Read data taken this edge
	logic mgmt_req; // Management interrupt request pulse
	logic resume_req; // Resume instruction executed
	logic mapped; // Address decodes
	pmc_mode_type live_mode; // Mode from the flags
	logic [63:0] gdt_q; // Widened table registers
	logic [63:0] idt_q;
	logic [63:0] ldt_q;
	logic [63:0] tsr_q;
	logic [63:0] bkp_q; // Breakpoint address

	// Zero-wait slave: every access completes in its first access cycle
	assign pready = 1'b1;
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign resume_req = wr && (paddr == `PMC_OFF_CTRL) && pwdata[`PMC_BIT_RESUME];

	pmc_mgmt_entry u_entry (
		.pclk(pclk),
		.presetn(presetn),
		.mgmt_interrupt_pin_n(mgmt_interrupt_pin_n),
		.mgmt_req(mgmt_req)
	);

	// Table and task registers widen only while long mode is active
	pmc_wide_reg #(.WIDTH(64)) u_gdt (
		.pclk(pclk), .presetn(presetn), .wide_en(long_mode_active),
		.wr_lo(wr && paddr == `PMC_OFF_GDT_LO), .wr_hi(wr && paddr == `PMC_OFF_GDT_HI),
		.wdata(pwdata), .value(gdt_q)
	);
	pmc_wide_reg #(.WIDTH(64)) u_idt (
		.pclk(pclk), .presetn(presetn), .wide_en(long_mode_active),
		.wr_lo(wr && paddr == `PMC_OFF_IDT_LO), .wr_hi(wr && paddr == `PMC_OFF_IDT_HI),
		.wdata(pwdata), .value(idt_q)
	);
	pmc_wide_reg #(.WIDTH(64)) u_ldt (
		.pclk(pclk), .presetn(presetn), .wide_en(long_mode_active),
		.wr_lo(wr && paddr == `PMC_OFF_LDT_LO), .wr_hi(wr && paddr == `PMC_OFF_LDT_HI),
		.wdata(pwdata), .value(ldt_q)
	);
	pmc_wide_reg #(.WIDTH(64)) u_tsr (
		.pclk(pclk), .presetn(presetn), .wide_en(long_mode_active),
		.wr_lo(wr && paddr == `PMC_OFF_TSR_LO), .wr_hi(wr && paddr == `PMC_OFF_TSR_HI),
		.wdata(pwdata), .value(tsr_q)
	);
	// Compatibility sub-mode still matches on all 64 bits, so width follows long mode
	pmc_wide_reg #(.WIDTH(64)) u_bkp (
		.pclk(pclk), .presetn(presetn), .wide_en(long_mode_active),
		.wr_lo(wr && paddr == `PMC_OFF_BKP_LO), .wr_hi(wr && paddr == `PMC_OFF_BKP_HI),
		.wdata(pwdata), .value(bkp_q)
	);

	// Mode derived from the flags when not in management mode
	always_comb begin
		if (!control_reg_zero[`PMC_BIT_PROT_EN]) begin
			live_mode = PMC_REAL;
		end else if (long_mode_active) begin
			live_mode = cs_attr[`PMC_BIT_CSL] ? PMC_BIT64 : PMC_COMPAT;
		end else if (system_flags_register[`PMC_BIT_V86]) begin
			live_mode = PMC_V86;
		end else begin
			live_mode = PMC_PROT;
		end
		current_mode = (state == PMC_IN_MGMT) ? PMC_MGMT : live_mode;
		fast_call_allowed = feat_lo[`PMC_BIT_FAST_CALL] && (current_mode == PMC_BIT64);
		execute_disable_enable = feat_lo[`PMC_BIT_XD_EN];
		mgmt_address_space = (state == PMC_IN_MGMT);
	end

	// Register writes, long mode activation and management entry/exit
	always_comb begin
		next_feat_lo = feat_lo;
		next_control_reg_zero = control_reg_zero;
		next_system_flags_register = system_flags_register;
		next_cs_attr = cs_attr;
		next_priority_control_reg = priority_control_reg;
		next_long_mode_active = long_mode_active;
		next_state = state;
		next_saved_mode = saved_mode;
		next_saved_ctl0 = saved_ctl0;
		next_saved_flags = saved_flags;
		next_saved_cs = saved_cs;
		if (wr) begin
			unique case (paddr)
				// Active bit and reserved bits ignore writes
				`PMC_OFF_FEAT_LO: next_feat_lo = pwdata & `PMC_FEAT_WMASK;
				`PMC_OFF_CTL0: next_control_reg_zero = pwdata;
				`PMC_OFF_FLAGS: begin
					next_system_flags_register = pwdata;
					// Virtual-8086 cannot be set in long mode
					if (long_mode_active) begin
						next_system_flags_register[`PMC_BIT_V86] = 1'b0;
					end
				end
				`PMC_OFF_CS: next_cs_attr = pwdata;
				`PMC_OFF_PRIO: begin
					if (long_mode_active) begin
						next_priority_control_reg = pwdata & `PMC_PRIO_MASK;
					end
				end
				default: begin
				end
			endcase
		end
		// Activation follows protection, paging and the enable bit
		next_long_mode_active = next_control_reg_zero[`PMC_BIT_PROT_EN] && next_control_reg_zero[`PMC_BIT_PG]
			&& next_feat_lo[`PMC_BIT_LONG_EN];
		if (next_long_mode_active) begin
			next_system_flags_register[`PMC_BIT_V86] = 1'b0;
		end
		unique case (state)
			PMC_RUN: begin
				if (mgmt_req) begin
					next_state = PMC_IN_MGMT;
					next_saved_mode = live_mode;
					next_saved_ctl0 = next_control_reg_zero;
					next_saved_flags = next_system_flags_register;
					next_saved_cs = next_cs_attr;
				end
			end
			PMC_IN_MGMT: begin
				// Further requests while inside are absorbed
				if (resume_req) begin
					next_state = PMC_RUN;
					next_control_reg_zero = saved_ctl0;
					next_system_flags_register = saved_flags;
					next_cs_attr = saved_cs;
					next_long_mode_active = (saved_mode == PMC_COMPAT) || (saved_mode == PMC_BIT64);
				end
			end
		endcase
	end

	// Read mux; unmapped addresses answer with an error
	always_comb begin
		mapped = 1'b1;
		next_prdata = prdata;
		next_pslverr = 1'b0;
		unique case (paddr)
			`PMC_OFF_FEAT_LO: next_prdata = feat_lo | ({31'h0, long_mode_active} << `PMC_BIT_LONG_ACT);
			`PMC_OFF_FEAT_HI: next_prdata = 32'h0;
			`PMC_OFF_CTL0: next_prdata = control_reg_zero;
			`PMC_OFF_FLAGS: next_prdata = system_flags_register;
			`PMC_OFF_CS: next_prdata = cs_attr;
			`PMC_OFF_CTRL: next_prdata = 32'h0;
			`PMC_OFF_MODE: next_prdata = {29'h0, current_mode};
			`PMC_OFF_PRIO: next_prdata = long_mode_active ? priority_control_reg : 32'h0;
			`PMC_OFF_GDT_LO: next_prdata = gdt_q[31:0];
			`PMC_OFF_GDT_HI: next_prdata = gdt_q[63:32];
			`PMC_OFF_IDT_LO: next_prdata = idt_q[31:0];
			`PMC_OFF_IDT_HI: next_prdata = idt_q[63:32];
			`PMC_OFF_LDT_LO: next_prdata = ldt_q[31:0];
			`PMC_OFF_LDT_HI: next_prdata = ldt_q[63:32];
			`PMC_OFF_TSR_LO: next_prdata = tsr_q[31:0];
			`PMC_OFF_TSR_HI: next_prdata = tsr_q[63:32];
			`PMC_OFF_BKP_LO: next_prdata = bkp_q[31:0];
			`PMC_OFF_BKP_HI: next_prdata = bkp_q[63:32];
			default: mapped = 1'b0;
		endcase
		if (!mapped) begin
			next_prdata = 32'h0;
		end
		// Setup cycle loads read data so it stands in the access cycle
		if (!(psel && !penable)) begin
			next_prdata = prdata;
		end
		next_pslverr = psel && !penable && !mapped;
		if (psel && penable) begin
			next_pslverr = pslverr;
		end
	end

	// State registers; reset lands in real-address mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			feat_lo <= `PMC_RESET_WORD;
			control_reg_zero <= `PMC_RESET_WORD;
			system_flags_register <= `PMC_RESET_WORD;
			cs_attr <= `PMC_RESET_WORD;
			priority_control_reg <= `PMC_RESET_WORD;
			long_mode_active <= 1'b0;
			state <= PMC_RUN;
			saved_mode <= PMC_REAL;
			saved_ctl0 <= `PMC_RESET_WORD;
			saved_flags <= `PMC_RESET_WORD;
			saved_cs <= `PMC_RESET_WORD;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			feat_lo <= next_feat_lo;
			control_reg_zero <= next_control_reg_zero;
			system_flags_register <= next_system_flags_register;
			cs_attr <= next_cs_attr;
			priority_control_reg <= next_priority_control_reg;
			long_mode_active <= next_long_mode_active;
			state <= next_state;
			saved_mode <= next_saved_mode;
			saved_ctl0 <= next_saved_ctl0;
			saved_flags <= next_saved_flags;
			saved_cs <= next_saved_cs;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end
endmodule // pmc_mode_ctrl

/* pmc_mode_ctrl_assertions.sv */
// Port checker for the mode control block, bound to its top module
`include "pmc_cfg.svh"
`timescale 1ns/1ps
module pmc_mode_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic mgmt_interrupt_pin_n,
	input wire pmc_pkg::pmc_mode_type current_mode,
	input wire logic fast_call_allowed,
	input wire logic execute_disable_enable,
	input wire logic mgmt_address_space
);
	import pmc_pkg::*;
	logic wr_now; // Completed write
	logic resume_wr; // Resume command
	logic pin_q; // Pin last cycle
	logic next_pin_q;
	pmc_mode_type saved_mode; // Mode left on entry
	pmc_mode_type next_saved_mode;
	assign wr_now = psel && penable && pwrite;
	assign resume_wr = wr_now && paddr == `PMC_OFF_CTRL && pwdata[`PMC_BIT_RESUME];
	// Capture the mode at an accepted request; ignored ones keep it
	always_comb begin
		next_pin_q = mgmt_interrupt_pin_n;
		next_saved_mode = saved_mode;
		if (pin_q && !mgmt_interrupt_pin_n && current_mode != PMC_MGMT) begin
			next_saved_mode = current_mode;
		end
	end
	// Helper state; pin assumed idle high at release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_q <= 1'b1;
			saved_mode <= PMC_REAL;
		end else begin
			pin_q <= next_pin_q;
			saved_mode <= next_saved_mode;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	reset_real_a: assert property ($rose(presetn) |-> current_mode == PMC_REAL)
		else $error("mode not real after reset");
	mgmt_entry_a: assert property ($fell(mgmt_interrupt_pin_n) && current_mode != PMC_MGMT |=> current_mode == PMC_MGMT)
		else $error("pin request did not enter management");
	mgmt_hold_a: assert property (current_mode == PMC_MGMT && !resume_wr |=> current_mode == PMC_MGMT)
		else $error("management left without resume");
	resume_back_a: assert property (current_mode == PMC_MGMT && resume_wr |=> current_mode == saved_mode)
		else $error("resume returned to wrong mode");
	mgmt_space_a: assert property (mgmt_address_space == (current_mode == PMC_MGMT))
		else $error("address space flag disagrees with mode");
	fast_call_a: assert property (fast_call_allowed |-> current_mode == PMC_BIT64)
		else $error("fast call allowed outside 64-bit");
	mode_read_a: assert property (psel && penable && !pwrite && paddr == `PMC_OFF_MODE
		|-> prdata == {29'h0, $past(current_mode)})
		else $error("mode readback wrong");
	xd_change_a: assert property ($changed(execute_disable_enable) |-> $past(wr_now && paddr == `PMC_OFF_FEAT_LO))
		else $error("execute disable changed without write");
	cover property (current_mode == PMC_BIT64);
	cover property ($fell(mgmt_interrupt_pin_n) && current_mode != PMC_MGMT);
	cover property (current_mode == PMC_MGMT && resume_wr);
endmodule // pmc_mode_checker

bind pmc_mode_ctrl pmc_mode_checker i_pmc_mode_checker (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .mgmt_interrupt_pin_n, .current_mode, .fast_call_allowed,
	.execute_disable_enable, .mgmt_address_space);

/* pmc_pin_model.sv */
// External system logic pulling the management pin low
`timescale 1ns/1ps
module pmc_pin_model (
	input wire logic pclk,
	input wire logic fire,
	input wire logic [3:0] width,
	output logic mgmt_interrupt_pin_n
);
	logic [3:0] cnt = 4'h0; // Low cycles left
	logic [3:0] next_cnt;
	// Width sets prompt or slow release
	always_comb begin
		next_cnt = cnt;
		if (fire) begin
			next_cnt = width;
		end else if (cnt != 4'h0) begin
			next_cnt = cnt - 4'h1;
		end
	end
	// Plain always: the start value comes from the declaration, no reset pin here
	always @(posedge pclk) begin
		cnt <= next_cnt;
	end
	assign mgmt_interrupt_pin_n = (cnt == 4'h0);
endmodule // pmc_pin_model

/* tb_processor_mode_control.sv */
// Self-checking bench for the mode control block
`include "pmc_cfg.svh"
`timescale 1ns/1ps
module tb_processor_mode_control;
	import pmc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pin_n;
	pmc_mode_type current_mode;
	logic fast_call_allowed;
	logic execute_disable_enable;
	logic mgmt_address_space;
	logic fire = 1'b0; // Partner trigger
	logic [3:0] width = 4'h1;
	logic [31:0] rd; // Last read word
	logic err;
	int err_count = 0;
	int compares = 0;
	// Rows: write address and data, readback address, expected word
	logic [11:0] t_wa [12] = '{12'h000, 12'h01c, 12'h024, 12'h008, 12'h00c, 12'h00c, 12'h008, 12'h000,
		12'h010, 12'h01c, 12'h024, 12'h00c};
	logic [31:0] t_wd [12] = '{32'hffffffff, 32'h000000ff, 32'haaaaaaaa, 32'h00000001, 32'h00020000,
		32'h00000000, 32'h80000001, 32'hffffffff, 32'h00000001, 32'h000000ff, 32'haaaaaaaa, 32'h00020000};
	logic [11:0] t_ra [12] = '{12'h000, 12'h01c, 12'h024, 12'h018, 12'h018, 12'h018, 12'h000, 12'h018,
		12'h018, 12'h01c, 12'h024, 12'h00c};
	logic [31:0] t_ex [12] = '{32'h00000901, 32'h00000000, 32'h00000000, 32'h00000001, 32'h00000002,
		32'h00000001, 32'h00000d01, 32'h00000003, 32'h00000004, 32'h0000000f, 32'haaaaaaaa, 32'h00000000};
	pmc_mode_ctrl i_pmc_mode_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mgmt_interrupt_pin_n(pin_n), .current_mode(current_mode),
		.fast_call_allowed(fast_call_allowed), .execute_disable_enable(execute_disable_enable),
		.mgmt_address_space(mgmt_address_space));
	pmc_pin_model i_pmc_pin_model (.pclk(pclk), .fire(fire), .width(width), .mgmt_interrupt_pin_n(pin_n));
	// 125 MHz clock
	always #4 pclk = ~pclk;
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Report and end the run
	task automatic stop_test();
		$display("Mismatches %0d, comparisons %0d", err_count, compares);
		if (err_count == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		if (n == 20) begin
			err_count++;
			stop_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Bounded wait for a mode
	task automatic wait_mode(input pmc_mode_type m);
		int n = 0;
		while (current_mode !== m && n < 20) begin
			n++;
			@(posedge pclk);
		end
		if (n == 20) begin
			err_count++;
			stop_test();
		end
	endtask
	// Ask the partner for one pin activation
	task automatic pulse(input logic [3:0] w);
		fire <= 1'b1;
		width <= w;
		@(posedge pclk);
		fire <= 1'b0;
		@(posedge pclk);
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk({29'h0, current_mode}, 32'h0);
		apb(1'b0, `PMC_OFF_FEAT_LO, 32'h0);
		chk(rd, 32'h0);
		for (int i = 0; i < 12; i++) begin
			apb(1'b1, t_wa[i], t_wd[i]);
			apb(1'b0, t_ra[i], 32'h0);
			chk(rd, t_ex[i]);
		end
		chk({31'h0, fast_call_allowed}, 32'h1);
		chk({31'h0, execute_disable_enable}, 32'h1);
		// Reserved upper feature word reads zero
		apb(1'b0, `PMC_OFF_FEAT_HI, 32'h0);
		chk(rd, 32'h0);
		// Breakpoint keeps all 64 bits in both long sub-modes
		apb(1'b1, `PMC_OFF_BKP_HI, 32'h12345678);
		apb(1'b1, `PMC_OFF_CS, 32'h0);
		apb(1'b0, `PMC_OFF_BKP_HI, 32'h0);
		chk(rd, 32'h12345678);
		apb(1'b0, `PMC_OFF_MODE, 32'h0);
		chk(rd, 32'h3);
		apb(1'b1, `PMC_OFF_CS, 32'h1);
		apb(1'b0, `PMC_OFF_BKP_HI, 32'h0);
		chk(rd, 32'h12345678);
		// Unmapped place is refused
		apb(1'b0, 12'h100, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		// Prompt request from 64-bit, then a slow one that must be ignored
		pulse(4'h1);
		wait_mode(PMC_MGMT);
		chk({31'h0, mgmt_address_space}, 32'h1);
		chk({31'h0, fast_call_allowed}, 32'h0);
		apb(1'b1, `PMC_OFF_CTL0, 32'h0);
		pulse(4'h9);
		repeat (4) begin
			apb(1'b0, `PMC_OFF_MODE, 32'h0);
			chk(rd, 32'h5);
		end
		apb(1'b1, `PMC_OFF_CTRL, 32'h1);
		apb(1'b0, `PMC_OFF_MODE, 32'h0);
		chk(rd, 32'h4);
		apb(1'b0, `PMC_OFF_CTL0, 32'h0);
		chk(rd, 32'h80000001);
		// Second reset mid-run, then a round trip from real mode
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk({29'h0, current_mode}, 32'h0);
		apb(1'b0, `PMC_OFF_GDT_HI, 32'h0);
		chk(rd, 32'h0);
		pulse(4'h1);
		wait_mode(PMC_MGMT);
		apb(1'b1, `PMC_OFF_CTRL, 32'h1);
		apb(1'b0, `PMC_OFF_MODE, 32'h0);
		chk(rd, 32'h0);
		stop_test();
	end
endmodule // tb_processor_mode_control
